// ### design/lmu_top.sv
// Long multiply unit: sequencer, accumulate, flags and control registers.
// Assumes decoder, register file and register bus on i_ref_clk.
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "lmu_consts.svh"
module lmu_top #(
    parameter int ADDR_W = 4
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // decoder
    input wire logic i_issue,
    input wire logic i_cond_pass,
    input wire logic i_signed,
    input wire logic i_accumulate,
    input wire logic i_set_flags,
    // operands from the register file
    input wire logic [31:0] i_multiplicand,
    input wire logic [31:0] i_multiplier,
    input wire logic [31:0] i_addend_lo,
    input wire logic [31:0] i_addend_hi,
    // register port
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // results
    output logic o_busy,
    output logic o_result_we,
    output logic [31:0] o_result_lo,
    output logic [31:0] o_result_hi,
    output logic o_flags_we,
    output logic o_flag_n,
    output logic o_flag_z,
    output logic o_flag_c,
    output logic o_flag_v
);
    // -----------------------------------------------------------------
    // elaboration check
    // -----------------------------------------------------------------
    if (ADDR_W < 3) begin : g_bad_addr
        $error("lmu_top: ADDR_W too small for the register map");
    end

    // -----------------------------------------------------------------
    // sequencer state
    // -----------------------------------------------------------------
    lmu_pkg::lmu_state_t state_r, state_nxt;
    logic signed [32:0] mcand_r, mcand_nxt;
    logic [31:0] mplr_r, mplr_nxt;
    logic [63:0] addend_r, addend_nxt;
    logic [63:0] prod_r, prod_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [1:0] fix_pos_r, fix_pos_nxt;
    logic neg_fix_r, neg_fix_nxt;
    logic signed_r, signed_nxt;
    logic acc_r, acc_nxt;
    logic setf_r, setf_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [2:0] last_cnt_r, last_cnt_nxt;
    logic [31:0] res_lo_r, res_lo_nxt;
    logic [31:0] res_hi_r, res_hi_nxt;
    logic flag_n_r, flag_n_nxt;
    logic flag_z_r, flag_z_nxt;
    logic ctrl_et_r, ctrl_et_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic take;
    logic [2:0] idx_p1;
    logic [5:0] rem_sh;
    logic rem_zero;
    logic rem_ones;
    logic [63:0] fix_val;
    logic [63:0] sum;
    logic sum_neg;
    logic sum_zero;

    lmu_pp_if pp_if ();

    lmu_digit_mul u_digit (
        .pp_if (pp_if.calc)
    );

    lmu_flag_gen u_flags (
        .i_result (sum),
        .o_neg (sum_neg),
        .o_zero (sum_zero)
    );

    // condition already resolved by the decoder; a failed one is dropped
    assign take = i_issue && i_cond_pass && (state_r == lmu_pkg::st_idle);

    // -----------------------------------------------------------------
    // digit step and early termination
    // -----------------------------------------------------------------
    // the top digit of a signed multiplier carries the sign weight
    assign pp_if.mcand = mcand_r;
    assign pp_if.digit = {signed_r && (idx_r == 2'h3) &&
        mplr_r[{idx_r, 3'h7}], mplr_r[{idx_r, 3'h0} +: 8]};
    assign pp_if.pos = idx_r;

    assign idx_p1 = {1'b0, idx_r} + 3'h1;
    assign rem_sh = {idx_p1, 3'h0};
    assign rem_zero = ((mplr_r >> rem_sh) == 32'h0);
    assign rem_ones = (((~mplr_r) >> rem_sh) == 32'h0);

    // all-ones upper bits weigh -1 at their position: take mcand off once
    assign fix_val = neg_fix_r ? (64'(mcand_r) << {fix_pos_r, 3'h0})
                               : 64'h0;
    assign sum = prod_r + (acc_r ? addend_r : 64'h0) - fix_val;

    always_comb begin
        state_nxt = state_r;
        mcand_nxt = mcand_r;
        mplr_nxt = mplr_r;
        addend_nxt = addend_r;
        prod_nxt = prod_r;
        idx_nxt = idx_r;
        fix_pos_nxt = fix_pos_r;
        neg_fix_nxt = neg_fix_r;
        signed_nxt = signed_r;
        acc_nxt = acc_r;
        setf_nxt = setf_r;
        cnt_nxt = cnt_r;
        last_cnt_nxt = last_cnt_r;
        res_lo_nxt = res_lo_r;
        res_hi_nxt = res_hi_r;
        flag_n_nxt = flag_n_r;
        flag_z_nxt = flag_z_r;
        case (state_r)
            lmu_pkg::st_idle: begin
                if (take) begin
                    // sign of the multiplicand follows the variant
                    mcand_nxt = {i_signed && i_multiplicand[31],
                        i_multiplicand};
                    mplr_nxt = i_multiplier;
                    // addend latched now, so later register writes cannot race
                    addend_nxt = {i_addend_hi, i_addend_lo};
                    signed_nxt = i_signed;
                    acc_nxt = i_accumulate;
                    setf_nxt = i_set_flags;
                    cnt_nxt = 3'h1;
                    state_nxt = lmu_pkg::st_load;
                end
            end
            lmu_pkg::st_load: begin
                prod_nxt = 64'h0;
                idx_nxt = 2'h0;
                neg_fix_nxt = 1'b0;
                fix_pos_nxt = 2'h0;
                cnt_nxt = cnt_r + 3'h1;
                state_nxt = lmu_pkg::st_iter;
            end
            lmu_pkg::st_iter: begin
                prod_nxt = prod_r + pp_if.pp;
                cnt_nxt = cnt_r + 3'h1;
                if (idx_r == 2'h3) begin
                    state_nxt = lmu_pkg::st_acc;
                end else if (ctrl_et_r && rem_zero) begin
                    state_nxt = lmu_pkg::st_acc;
                end else if (ctrl_et_r && signed_r && rem_ones) begin
                    neg_fix_nxt = 1'b1;
                    fix_pos_nxt = idx_p1[1:0];
                    state_nxt = lmu_pkg::st_acc;
                end else begin
                    idx_nxt = idx_r + 2'h1;
                end
            end
            lmu_pkg::st_acc: begin
                res_lo_nxt = sum[31:0];
                res_hi_nxt = sum[63:32];
                if (setf_r) begin
                    flag_n_nxt = sum_neg;
                    flag_z_nxt = sum_zero;
                end
                cnt_nxt = cnt_r + 3'h1;
                state_nxt = lmu_pkg::st_wb;
            end
            lmu_pkg::st_wb: begin
                last_cnt_nxt = cnt_r;
                state_nxt = lmu_pkg::st_idle;
            end
            default: begin
                state_nxt = lmu_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r <= lmu_pkg::st_idle;
            mcand_r <= 33'h0;
            mplr_r <= 32'h0;
            addend_r <= 64'h0;
            prod_r <= 64'h0;
            idx_r <= 2'h0;
            fix_pos_r <= 2'h0;
            neg_fix_r <= 1'b0;
            signed_r <= 1'b0;
            acc_r <= 1'b0;
            setf_r <= 1'b0;
            cnt_r <= 3'h0;
            last_cnt_r <= 3'h0;
            res_lo_r <= 32'h0;
            res_hi_r <= 32'h0;
            flag_n_r <= 1'b0;
            flag_z_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mcand_r <= mcand_nxt;
            mplr_r <= mplr_nxt;
            addend_r <= addend_nxt;
            prod_r <= prod_nxt;
            idx_r <= idx_nxt;
            fix_pos_r <= fix_pos_nxt;
            neg_fix_r <= neg_fix_nxt;
            signed_r <= signed_nxt;
            acc_r <= acc_nxt;
            setf_r <= setf_nxt;
            cnt_r <= cnt_nxt;
            last_cnt_r <= last_cnt_nxt;
            res_lo_r <= res_lo_nxt;
            res_hi_r <= res_hi_nxt;
            flag_n_r <= flag_n_nxt;
            flag_z_r <= flag_z_nxt;
        end
    end

    // -----------------------------------------------------------------
    // register port
    // -----------------------------------------------------------------
    always_comb begin
        ctrl_et_nxt = ctrl_et_r;
        rdata_nxt = 32'h0;
        if (i_reg_wr && (i_reg_addr == ADDR_W'(`LMU_CTRL_OFS))) begin
            ctrl_et_nxt = i_reg_wdata[`LMU_CTRL_ET_BIT];
        end
        if (i_reg_rd) begin
            if (i_reg_addr == ADDR_W'(`LMU_CTRL_OFS)) begin
                rdata_nxt[`LMU_CTRL_ET_BIT] = ctrl_et_r;
            end else if (i_reg_addr == ADDR_W'(`LMU_STAT_OFS)) begin
                rdata_nxt[`LMU_STAT_CNT_LSB +: `LMU_STAT_CNT_W] = last_cnt_r;
                rdata_nxt[`LMU_STAT_BUSY_BIT] = o_busy;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ctrl_et_r <= `LMU_CTRL_ET_RESET;
            rdata_r <= 32'h0;
        end else begin
            ctrl_et_r <= ctrl_et_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign o_reg_rdata = rdata_r;
    assign o_busy = (state_r != lmu_pkg::st_idle);
    assign o_result_we = (state_r == lmu_pkg::st_wb);
    assign o_result_lo = res_lo_r;
    assign o_result_hi = res_hi_r;
    assign o_flags_we = (state_r == lmu_pkg::st_wb) && setf_r;
    assign o_flag_n = flag_n_r;
    assign o_flag_z = flag_z_r;
    // meaningless flags driven low so the bench sees no unknowns
    assign o_flag_c = 1'b0;
    assign o_flag_v = 1'b0;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    logic [63:0] ref_u;
    logic signed [63:0] ref_s;
    logic [63:0] ref_add;

    assign ref_u = {32'h0, mcand_r[31:0]} * {32'h0, mplr_r};
    assign ref_s = 64'($signed(mcand_r[31:0])) * 64'($signed(mplr_r));
    assign ref_add = acc_r ? addend_r : 64'h0;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    a_cond_fail_quiet:
    assert property (i_issue && !i_cond_pass && !o_busy
        |=> !o_busy ##1 !o_result_we)
    else $error("failed condition started an operation");

    a_cycle_window:
    assert property (take |-> ##[4:7] o_result_we)
    else $error("operation did not finish in 4 to 7 cycles");

    a_cycle_count:
    assert property (o_result_we |-> cnt_r >= 3'h4 && cnt_r <= 3'h7)
    else $error("operation length outside 4 to 7");

    a_no_flag_write:
    assert property (take && !i_set_flags |=> !o_flags_we [*7])
    else $error("flags written without the update bit");

    a_neg_bit63:
    assert property (o_flags_we |-> o_flag_n == o_result_hi[31])
    else $error("negative flag differs from bit 63");

    a_zero_full:
    assert property (o_flags_we
        |-> o_flag_z == ({o_result_hi, o_result_lo} == 64'h0))
    else $error("zero flag wrong");

    a_unsigned_mul:
    assert property (o_result_we && !signed_r
        |-> {o_result_hi, o_result_lo} == ref_u + ref_add)
    else $error("unsigned result wrong");

    a_signed_mul:
    assert property (o_result_we && signed_r
        |-> {o_result_hi, o_result_lo} == 64'(ref_s) + ref_add)
    else $error("signed result wrong");

    a_early_zero:
    assert property (take && ctrl_et_r && i_multiplier == 32'h0
        |-> ##4 o_result_we)
    else $error("zero multiplier did not end in 4 cycles");

    a_result_hold:
    assert property (!o_busy && !take |=> $stable(o_result_lo))
    else $error("result changed while idle");

    c_signed_mac: cover property (o_result_we && signed_r && acc_r);
    c_short_op: cover property (o_result_we && cnt_r == 3'h4);
    c_full_op: cover property (o_result_we && cnt_r == 3'h7);
    c_neg_fix: cover property (o_result_we && neg_fix_r);
endmodule // lmu_top
`default_nettype wire

// ### design/lmu_consts.svh
// Constants of the long multiply unit: offsets, fields, resets, cycle counts.
// Assumes inclusion by bare name from each design file that needs them.
//
// Contract
// - An instruction whose condition fails changes no result and no flag.
// - The plain form writes the low product half to the low result and the high half to the high result.
// - The accumulate forms add the 64-bit addend from the result pair to the product and write the sum back.
// - The unsigned forms treat every operand, addend included, as unsigned and give an unsigned result.
// - The signed forms treat every operand as two's complement and give a signed 64-bit result.
// - Flags in the status word change only when the flag-update bit is set.
// - On a flag update the negative flag equals bit 63 of the result.
// - On a flag update the zero flag is set exactly when all 64 result bits are zero.
// - On a flag update carry and overflow take a value nobody may rely on.
// - An operation takes 7 cycles less an early termination of 0 to 3, so 4 to 7.
`ifndef LMU_CONSTS_SVH
`define LMU_CONSTS_SVH

`define LMU_WORD_W 32
`define LMU_PROD_W 64
`define LMU_DIGIT_W 8
`define LMU_DIGITS 4
`define LMU_BASIC_CYCLES 7
`define LMU_EARLY_MAX 3
`define LMU_MIN_CYCLES (`LMU_BASIC_CYCLES - `LMU_EARLY_MAX)

`define LMU_CTRL_OFS 4'h0
`define LMU_STAT_OFS 4'h4
`define LMU_CTRL_ET_BIT 0
`define LMU_CTRL_ET_RESET 1'b1
`define LMU_STAT_CNT_LSB 0
`define LMU_STAT_CNT_W 3
`define LMU_STAT_BUSY_BIT 8

`endif

// ### design/lmu_pkg.sv
// Types shared by the long multiply unit.
// Assumes nothing beyond a SystemVerilog compiler.
package lmu_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_load,
        st_iter,
        st_acc,
        st_wb
    } lmu_state_t;

endpackage

// ### design/lmu_pp_if.sv
// Carrier between the sequencer and the partial product multiplier.
// Assumes one digit step per clock, purely combinational answer.
`timescale 1ns/1ns
`default_nettype none
interface lmu_pp_if;
    logic signed [32:0] mcand;
    logic signed [8:0] digit;
    logic [1:0] pos;
    logic [63:0] pp;

    modport src (output mcand, output digit, output pos, input pp);
    modport calc (input mcand, input digit, input pos, output pp);
endinterface
`default_nettype wire

// ### design/lmu_digit_mul.sv
// Partial product of one signed 9-bit multiplier digit.
// Assumes the sequencer holds mcand, digit and pos stable in the step.
`timescale 1ns/1ns
`default_nettype none
module lmu_digit_mul (
    // operand side
    lmu_pp_if.calc pp_if
);
    logic signed [41:0] raw;
    logic [63:0] ext;

    always_comb begin
        raw = pp_if.mcand * pp_if.digit;
        ext = 64'(raw);
        pp_if.pp = ext << {pp_if.pos, 3'h0};
    end
endmodule // lmu_digit_mul
`default_nettype wire

// ### design/lmu_flag_gen.sv
// Negative and zero flags of a 64-bit result.
// Assumes a combinational caller that registers the outputs.
`timescale 1ns/1ns
`default_nettype none
module lmu_flag_gen (
    // result
    input wire logic [63:0] i_result,
    // flags
    output logic o_neg,
    output logic o_zero
);
    assign o_neg = i_result[63];
    assign o_zero = (i_result == 64'h0);
endmodule // lmu_flag_gen
`default_nettype wire

// ### tb/lmu_rf_model.sv
// Register file stand-in: holds the result pair that feeds the addend.
// Assumes the bench preloads the pair and the unit writes it back.
`timescale 1ns/1ns
`default_nettype none
module lmu_rf_model (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // bench preload
    input wire logic i_load,
    input wire logic [63:0] i_load_val,
    // unit write-back
    input wire logic i_result_we,
    input wire logic [31:0] i_result_lo,
    input wire logic [31:0] i_result_hi,
    // addend to the unit
    output logic [31:0] o_addend_lo,
    output logic [31:0] o_addend_hi
);
    logic [63:0] pair_r;

    // hi and lo live in two slots of their own, apart from the multiplicand
    always_ff @(posedge i_ref_clk) begin
        if (i_rst)
            pair_r <= 64'h0;
        else if (i_load)
            pair_r <= i_load_val;
        else if (i_result_we)
            pair_r <= {i_result_hi, i_result_lo};
    end

    // general slots only: no program counter path exists here
    assign o_addend_lo = pair_r[31:0];
    assign o_addend_hi = pair_r[63:32];
endmodule // lmu_rf_model
`default_nettype wire

// ### tb/long_multiply_unit_tb.sv
// Self-checking bench of the long multiply unit.
// Assumes lmu_top and the register file stand-in compiled before it.
`timescale 1ns/1ns
`default_nettype none
module long_multiply_unit_tb;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic issue = 1'b0, cond = 1'b0, sgn = 1'b0, acc = 1'b0, sf = 1'b0;
    logic wr = 1'b0, rd = 1'b0, ld = 1'b0, et = 1'b1;
    logic [31:0] mcand = 32'h0, mplier = 32'h0, wdata = 32'h0;
    logic [31:0] rdata, res_lo, res_hi, add_lo, add_hi, rv;
    logic [3:0] addr = 4'h0;
    logic [63:0] ld_val = 64'h0, pair = 64'h0, last = 64'h0;
    logic busy, rwe, fwe, fn, fz, fc, fv;
    logic [1:0] flags = 2'h0;
    int cnt = 0;
    int miscompares = 0;
    int samples_checked = 0;
    // c s a f, multiplicand, multiplier
    logic [67:0] tbl [10] = '{
        {4'hB, 32'h00000001, 32'h00000001}, {4'h9, 32'h00000007, 32'h0},
        {4'h9, 32'hFFFFFFFF, 32'h000000FF}, {4'hD, 32'hFFFFFFF6, 32'h0000FFFF},
        {4'hC, 32'h12345678, 32'hFFFFFFF0}, {4'hB, 32'h80000000, 32'h00FFFFFF},
        {4'h7, 32'h7FFFFFFF, 32'h80000000}, {4'hF, 32'h7FFFFFFF, 32'h80000000},
        {4'h9, 32'h00000002, 32'hFFFFFFF0}, {4'hE, 32'hFFFFFFFF, 32'hFFFFFFFF}};

    always #4 i_ref_clk = ~i_ref_clk;

    lmu_top lmu_top_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_issue(issue),
        .i_cond_pass(cond), .i_signed(sgn), .i_accumulate(acc),
        .i_set_flags(sf), .i_multiplicand(mcand), .i_multiplier(mplier),
        .i_addend_lo(add_lo), .i_addend_hi(add_hi), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .o_busy(busy), .o_result_we(rwe),
        .o_result_lo(res_lo), .o_result_hi(res_hi), .o_flags_we(fwe),
        .o_flag_n(fn), .o_flag_z(fz), .o_flag_c(fc), .o_flag_v(fv));

    lmu_rf_model lmu_rf_model_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_load(ld), .i_load_val(ld_val), .i_result_we(rwe),
        .i_result_lo(res_lo), .i_result_hi(res_hi),
        .o_addend_lo(add_lo), .o_addend_hi(add_hi));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [63:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_ref_clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_ref_clk);
        rd <= 1'b0;
        @(negedge i_ref_clk);
        d = rdata;
    endtask

    task automatic op(input logic [67:0] e);
        logic c, s, a, f;
        logic [31:0] m, r;
        logic [63:0] p;
        int n, k;
        {c, s, a, f, m, r} = e;
        p = {{32{s & m[31]}}, m} * {{32{s & r[31]}}, r};
        if (a)
            p = p + pair;
        n = 4;
        for (k = 3; k >= 1; k--)
            if (et && ((r >> 8 * k) == 0 || s && (~r >> 8 * k) == 0))
                n = k;
        @(posedge i_ref_clk);
        issue <= 1'b1;
        cond <= c;
        sgn <= s;
        acc <= a;
        sf <= f;
        mcand <= m;
        mplier <= r;
        @(posedge i_ref_clk);
        issue <= 1'b0;
        // a failed condition never strobes, so the loop runs out at 10
        for (k = 1; k < 10; k++) begin
            @(negedge i_ref_clk);
            if (k == 1)
                chk("busy", {63'h0, c}, {63'h0, busy});
            if (rwe === 1'b1)
                break;
        end
        chk("cycles", 64'(c ? n + 3 : 10), 64'(k));
        chk("flags_we", {63'h0, c & f}, {63'h0, fwe});
        if (c) begin
            last = p;
            pair = p;
            cnt = n + 3;
            if (f)
                flags = {p[63], p == 64'h0};
        end
        chk("result", last, {res_hi, res_lo});
        chk("flags", {62'h0, flags}, {62'h0, fn, fz});
        chk("flags_cv", 64'h0, {62'h0, fc, fv});
        reg_rd(4'h4, rv);
        chk("stat", 64'(cnt), {32'h0, rv});
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        reg_rd(4'h0, rv);
        chk("ctrl", 64'h1, {32'h0, rv});
        reg_rd(4'h4, rv);
        chk("stat", 64'h0, {32'h0, rv});
        reg_rd(4'h8, rv);
        chk("unmapped", 64'h0, {32'h0, rv});
        $display("test reset done");
        // addend of all ones makes the first accumulate wrap to zero
        @(posedge i_ref_clk);
        ld <= 1'b1;
        ld_val <= 64'hFFFFFFFFFFFFFFFF;
        @(posedge i_ref_clk);
        ld <= 1'b0;
        pair = 64'hFFFFFFFFFFFFFFFF;
        for (int i = 0; i < 10; i++)
            op(tbl[i]);
        $display("test variants done");
        reg_wr(4'h0, 32'h0);
        et = 1'b0;
        reg_wr(4'h8, 32'hFFFFFFFF);
        reg_wr(4'h4, 32'hFFFFFFFF);
        op({4'h9, 32'h00000003, 32'h0});
        reg_rd(4'h0, rv);
        chk("ctrl", 64'h0, {32'h0, rv});
        reg_rd(4'h8, rv);
        chk("unmapped", 64'h0, {32'h0, rv});
        $display("test full count done");
        // reset while idle must clear results, count and restore the enable
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        @(posedge i_ref_clk);
        i_rst <= 1'b0;
        reg_rd(4'h4, rv);
        chk("stat", 64'h0, {32'h0, rv});
        chk("result", 64'h0, {res_hi, res_lo});
        chk("flags", 64'h0, {62'h0, fn, fz});
        reg_rd(4'h0, rv);
        chk("ctrl", 64'h1, {32'h0, rv});
        $display("test reset again done");
        conclude;
    end

    initial begin
        #(8 * 20000);
        miscompares++;
        conclude;
    end
endmodule // long_multiply_unit_tb
`default_nettype wire
